// >>> verilog/phy_strap_latch.v
// strap latch: captures reset straps and holds them as control register defaults
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "phy_strap_latch_defs.vh"
module phy_strap_latch (
   input wire CLOCK_IN,
   input wire RST_IN,
   input wire [`REG_ADDR_W-1:0] REG_ADDR_IN,
   input wire [`REG_DATA_W-1:0] REG_WDATA_IN,
   input wire REG_WR_IN,
   input wire REG_RD_IN,
   output reg [`REG_DATA_W-1:0] REG_RDATA_OUT,
   input wire MGMT_ADDR_STRAP_BIT0_IN,
   output wire MGMT_ADDR_STRAP_BIT0_OUT,
   output wire MGMT_ADDR_STRAP_BIT0_OE_OUT,
   input wire MGMT_ADDR_STRAP_BIT1_IN,
   output wire MGMT_ADDR_STRAP_BIT1_OUT,
   output wire MGMT_ADDR_STRAP_BIT1_OE_OUT,
   input wire MGMT_ADDR_STRAP_BIT2_IN,
   output wire MGMT_ADDR_STRAP_BIT2_OUT,
   output wire MGMT_ADDR_STRAP_BIT2_OE_OUT,
   input wire IF_MODE_STRAP_BIT0_IN,
   output wire IF_MODE_STRAP_BIT0_OUT,
   output wire IF_MODE_STRAP_BIT0_OE_OUT,
   input wire IF_MODE_STRAP_BIT1_IN,
   output wire IF_MODE_STRAP_BIT1_OUT,
   output wire IF_MODE_STRAP_BIT1_OE_OUT,
   input wire IF_MODE_STRAP_BIT2_IN,
   output wire IF_MODE_STRAP_BIT2_OUT,
   output wire IF_MODE_STRAP_BIT2_OE_OUT,
   input wire ISOLATE_STRAP_IN,
   output wire ISOLATE_STRAP_OUT,
   output wire ISOLATE_STRAP_OE_OUT,
   input wire SPEED_STRAP_IN,
   output wire SPEED_STRAP_OUT,
   output wire SPEED_STRAP_OE_OUT,
   input wire DUPLEX_STRAP_IN,
   output wire DUPLEX_STRAP_OUT,
   output wire DUPLEX_STRAP_OE_OUT,
   input wire AUTONEG_ENABLE_STRAP_IN,
   output wire AUTONEG_ENABLE_STRAP_OUT,
   output wire AUTONEG_ENABLE_STRAP_OE_OUT,
   input wire [`STRAP_PINS-1:0] PIN_FUNC_IN,
   output wire [`STRAP_PINS-1:0] STRAP_PULL_UP_OUT,
   output wire STRAP_PULL_EN_OUT,
   output wire [4:0] MGMT_ADDR_OUT,
   output wire [2:0] IF_MODE_OUT,
   output wire MODE_MII_OUT,
   output wire MODE_RMII_OUT,
   output wire MODE_RESTORE_OUT,
   output wire MODE_RESERVED_OUT,
   output wire ISOLATE_OUT,
   output wire SPEED_100_OUT,
   output wire DUPLEX_BIT_OUT,
   output wire AUTONEG_EN_OUT,
   output wire [3:0] ADV_ABILITY_OUT,
   output wire STRAPS_LOADED_OUT
);

   // ==========================================================
   // states
   localparam [1:0] ST_HOLD = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;

   // ==========================================================
   // declarations
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg [4:0] mgmt_addr_q;
   reg [2:0] mode_q;
   reg ctrl_speed_q;
   reg ctrl_aneg_q;
   reg ctrl_iso_q;
   reg ctrl_duplex_q;
   reg [3:0] adv_q;
   reg [`REG_DATA_W-1:0] rdata_d;
   reg [`REG_DATA_W-1:0] ctrl_word;
   reg [`REG_DATA_W-1:0] adv_word;
   reg [`REG_DATA_W-1:0] strap_word;
   wire [`STRAP_PINS-1:0] pin_in;
   wire [`STRAP_PINS-1:0] pin_out;
   wire [`STRAP_PINS-1:0] pin_oe;
   wire [`STRAP_PINS-1:0] sample_q;
   wire load;
   wire wr_ctrl;
   wire wr_adv;
   wire mode_mii;
   wire mode_rmii;
   wire mode_restore;
   wire mode_reserved;

   // ==========================================================
   // helpers
   // address compare shared by the write decode and the read mux
   function hit;
      input [`REG_ADDR_W-1:0] addr;
      input [`REG_ADDR_W-1:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // ability bits that a given speed selection allows
   // a 10 Mb/s strap keeps the 100 Mb/s abilities off so the partner cannot pick them
   function [3:0] speed_abilities;
      input speed_100;
      begin
         if (speed_100) begin
            speed_abilities = 4'hF;
         end else begin
            speed_abilities = 4'h3;
         end
      end
   endfunction

   // ==========================================================
   // pin gathering
   // the vector order is the one the pull direction constant and the pin bank use
   assign pin_in[`PIN_ADDR0] = MGMT_ADDR_STRAP_BIT0_IN;
   assign pin_in[`PIN_ADDR1] = MGMT_ADDR_STRAP_BIT1_IN;
   assign pin_in[`PIN_ADDR2] = MGMT_ADDR_STRAP_BIT2_IN;
   assign pin_in[`PIN_MODE0] = IF_MODE_STRAP_BIT0_IN;
   assign pin_in[`PIN_MODE1] = IF_MODE_STRAP_BIT1_IN;
   assign pin_in[`PIN_MODE2] = IF_MODE_STRAP_BIT2_IN;
   assign pin_in[`PIN_ISO] = ISOLATE_STRAP_IN;
   assign pin_in[`PIN_SPEED] = SPEED_STRAP_IN;
   assign pin_in[`PIN_DUPLEX] = DUPLEX_STRAP_IN;
   assign pin_in[`PIN_ANEG] = AUTONEG_ENABLE_STRAP_IN;

   assign MGMT_ADDR_STRAP_BIT0_OUT = pin_out[`PIN_ADDR0];
   assign MGMT_ADDR_STRAP_BIT1_OUT = pin_out[`PIN_ADDR1];
   assign MGMT_ADDR_STRAP_BIT2_OUT = pin_out[`PIN_ADDR2];
   assign IF_MODE_STRAP_BIT0_OUT = pin_out[`PIN_MODE0];
   assign IF_MODE_STRAP_BIT1_OUT = pin_out[`PIN_MODE1];
   assign IF_MODE_STRAP_BIT2_OUT = pin_out[`PIN_MODE2];
   assign ISOLATE_STRAP_OUT = pin_out[`PIN_ISO];
   assign SPEED_STRAP_OUT = pin_out[`PIN_SPEED];
   assign DUPLEX_STRAP_OUT = pin_out[`PIN_DUPLEX];
   assign AUTONEG_ENABLE_STRAP_OUT = pin_out[`PIN_ANEG];

   assign MGMT_ADDR_STRAP_BIT0_OE_OUT = pin_oe[`PIN_ADDR0];
   assign MGMT_ADDR_STRAP_BIT1_OE_OUT = pin_oe[`PIN_ADDR1];
   assign MGMT_ADDR_STRAP_BIT2_OE_OUT = pin_oe[`PIN_ADDR2];
   assign IF_MODE_STRAP_BIT0_OE_OUT = pin_oe[`PIN_MODE0];
   assign IF_MODE_STRAP_BIT1_OE_OUT = pin_oe[`PIN_MODE1];
   assign IF_MODE_STRAP_BIT2_OE_OUT = pin_oe[`PIN_MODE2];
   assign ISOLATE_STRAP_OE_OUT = pin_oe[`PIN_ISO];
   assign SPEED_STRAP_OE_OUT = pin_oe[`PIN_SPEED];
   assign DUPLEX_STRAP_OE_OUT = pin_oe[`PIN_DUPLEX];
   assign AUTONEG_ENABLE_STRAP_OE_OUT = pin_oe[`PIN_ANEG];

   // ==========================================================
   // pull resistors: active only while the pins are inputs
   // the pull directions make an unstrapped part come up at address 1,
   // mii, not isolated, 100 Mb/s, half duplex, autoneg on
   assign STRAP_PULL_UP_OUT = `STRAP_PULLUP;
   assign STRAP_PULL_EN_OUT = st_q[0];

   // ==========================================================
   // pin bank
   // pins are registered in both directions so the load sees a stable sample
   strap_pin_bank #(
      .N(`STRAP_PINS)
   ) u_bank (
      .clk_in(CLOCK_IN),
      .rst_in(RST_IN),
      .pin_in(pin_in),
      .func_in(PIN_FUNC_IN),
      .sample_out(sample_q),
      .pin_out(pin_out),
      .pin_oe_out(pin_oe)
   );

   // ==========================================================
   // sequencing
   // hold covers the reset and exactly one edge after it; run lasts until the next reset
   always @* begin
      case (st_q)
         ST_HOLD: begin
            st_d = ST_RUN;
         end
         ST_RUN: begin
            st_d = ST_RUN;
         end
         default: begin
            st_d = ST_HOLD;
         end
      endcase
   end

   always @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         st_q <= ST_HOLD;
      end else begin
         st_q <= st_d;
      end
   end

   // the first edge after release moves the samples into the registers
   // a write in that same cycle is lost, so software must wait one more edge
   assign load = st_q[0];

   // ==========================================================
   // strap results
   // address and mode have no write path: only a new reset can change them
   always @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         mgmt_addr_q <= 5'h01;
         mode_q <= `MODE_MII;
      end else if (load) begin
         // an all-low address strap is kept as sampled; the device's own
         // pull-up on address bit 0, set by STRAP_PULLUP, is what keeps it from happening by accident
         mgmt_addr_q <= {`MGMT_ADDR_HI, sample_q[`PIN_ADDR2:`PIN_ADDR0]};
         mode_q <= sample_q[`PIN_MODE2:`PIN_MODE0];
      end
   end

   // ==========================================================
   // register writes
   // unmapped addresses and the read-only status word simply drop a write
   // the duplex bit keeps the pin polarity, so a one reads back as half duplex
   assign wr_ctrl = REG_WR_IN && hit(REG_ADDR_IN, `REG_CTRL);
   assign wr_adv = REG_WR_IN && hit(REG_ADDR_IN, `REG_ADV);

   always @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         ctrl_speed_q <= 1'b1;
         ctrl_aneg_q <= 1'b1;
         ctrl_iso_q <= 1'b0;
         ctrl_duplex_q <= 1'b1;
      end else if (load) begin
         // loading beats a write in the same cycle so the straps always land
         ctrl_speed_q <= sample_q[`PIN_SPEED];
         ctrl_aneg_q <= sample_q[`PIN_ANEG];
         ctrl_iso_q <= sample_q[`PIN_ISO];
         ctrl_duplex_q <= sample_q[`PIN_DUPLEX];
      end else if (wr_ctrl) begin
         ctrl_speed_q <= REG_WDATA_IN[`CTRL_SPEED_BIT];
         ctrl_aneg_q <= REG_WDATA_IN[`CTRL_ANEG_BIT];
         ctrl_iso_q <= REG_WDATA_IN[`CTRL_ISO_BIT];
         ctrl_duplex_q <= REG_WDATA_IN[`CTRL_DUPLEX_BIT];
      end
   end

   always @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         adv_q <= 4'hF;
      end else if (load) begin
         adv_q <= speed_abilities(sample_q[`PIN_SPEED]);
      end else if (wr_adv) begin
         adv_q <= REG_WDATA_IN[`ADV_100FD_BIT:`ADV_10HD_BIT];
      end
   end

   // ==========================================================
   // register reads
   // fields that are not implemented read as zero, never as stale data
   always @* begin
      ctrl_word = {`REG_DATA_W{1'b0}};
      ctrl_word[`CTRL_SPEED_BIT] = ctrl_speed_q;
      ctrl_word[`CTRL_ANEG_BIT] = ctrl_aneg_q;
      ctrl_word[`CTRL_ISO_BIT] = ctrl_iso_q;
      ctrl_word[`CTRL_DUPLEX_BIT] = ctrl_duplex_q;
   end

   always @* begin
      adv_word = {`REG_DATA_W{1'b0}};
      adv_word[`ADV_100FD_BIT:`ADV_10HD_BIT] = adv_q;
      adv_word[4:0] = `ADV_SELECTOR;
   end

   // status word: address, mode, reserved flag and load flag, all read only
   always @* begin
      strap_word = {`REG_DATA_W{1'b0}};
      strap_word[`STRAP_ADDR_LSB+4:`STRAP_ADDR_LSB] = mgmt_addr_q;
      strap_word[`STRAP_MODE_LSB+2:`STRAP_MODE_LSB] = mode_q;
      strap_word[`STRAP_RSVD_BIT] = mode_reserved;
      strap_word[`STRAP_LOADED_BIT] = st_q[1];
   end

   always @* begin
      rdata_d = {`REG_DATA_W{1'b0}};
      if (hit(REG_ADDR_IN, `REG_CTRL)) begin
         rdata_d = ctrl_word;
      end else if (hit(REG_ADDR_IN, `REG_ADV)) begin
         rdata_d = adv_word;
      end else if (hit(REG_ADDR_IN, `REG_STRAP)) begin
         rdata_d = strap_word;
      end
   end

   // read data stand only in the cycle after the strobe, zero otherwise
   // zeroing between reads keeps a stale word from being taken for a fresh one
   always @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         REG_RDATA_OUT <= {`REG_DATA_W{1'b0}};
      end else if (REG_RD_IN) begin
         REG_RDATA_OUT <= rdata_d;
      end else begin
         REG_RDATA_OUT <= {`REG_DATA_W{1'b0}};
      end
   end

   // ==========================================================
   // mode decode
   // reserved codes are decoded once here so every user sees the same fallback
   if_mode_decode u_mode (
      .code_in(mode_q),
      .mii_out(mode_mii),
      .rmii_out(mode_rmii),
      .restore_out(mode_restore),
      .reserved_out(mode_reserved)
   );

   // ==========================================================
   // outputs to the rest of the transceiver
   // all come from flip-flops or a decode of them, settled on the load edge itself
   assign MGMT_ADDR_OUT = mgmt_addr_q;
   assign IF_MODE_OUT = mode_q;
   assign MODE_MII_OUT = mode_mii;
   assign MODE_RMII_OUT = mode_rmii;
   assign MODE_RESTORE_OUT = mode_restore;
   assign MODE_RESERVED_OUT = mode_reserved;
   assign ISOLATE_OUT = ctrl_iso_q;
   assign SPEED_100_OUT = ctrl_speed_q;
   assign DUPLEX_BIT_OUT = ctrl_duplex_q;
   assign AUTONEG_EN_OUT = ctrl_aneg_q;
   assign ADV_ABILITY_OUT = adv_q;
   assign STRAPS_LOADED_OUT = st_q[1];

endmodule // phy_strap_latch

// >>> verilog/phy_strap_latch_defs.vh
// constants shared by the strap latch and its helper modules
`ifndef PHY_STRAP_LATCH_DEFS_VH
`define PHY_STRAP_LATCH_DEFS_VH

// ==========================================================
// register port
`define REG_ADDR_W 5
`define REG_DATA_W 16
`define REG_CTRL 5'h00
`define REG_ADV 5'h04
`define REG_STRAP 5'h18

// ==========================================================
// control register fields
`define CTRL_SPEED_BIT 13
`define CTRL_ANEG_BIT 12
`define CTRL_ISO_BIT 10
`define CTRL_DUPLEX_BIT 8

// ==========================================================
// advertisement register fields
`define ADV_100FD_BIT 8
`define ADV_100HD_BIT 7
`define ADV_10FD_BIT 6
`define ADV_10HD_BIT 5
`define ADV_SELECTOR 5'h01

// ==========================================================
// strap status register fields
`define STRAP_ADDR_LSB 0
`define STRAP_MODE_LSB 5
`define STRAP_RSVD_BIT 8
`define STRAP_LOADED_BIT 9

// ==========================================================
// strap pin positions and pull directions
`define STRAP_PINS 10
`define PIN_ADDR0 0
`define PIN_ADDR1 1
`define PIN_ADDR2 2
`define PIN_MODE0 3
`define PIN_MODE1 4
`define PIN_MODE2 5
`define PIN_ISO 6
`define PIN_SPEED 7
`define PIN_DUPLEX 8
`define PIN_ANEG 9
`define STRAP_PULLUP 10'h381

// ==========================================================
// interface modes and address layout
`define MODE_MII 3'h0
`define MODE_RMII 3'h1
`define MODE_RESTORE 3'h4
`define MGMT_ADDR_HI 2'h0

`endif

// >>> verilog/strap_pin_bank.v
// strap pin bank: samples pins during reset, drives their normal function after
`timescale 1ns/1ps
module strap_pin_bank #(
   parameter N = 10
) (
   input wire clk_in,
   input wire rst_in,
   input wire [N-1:0] pin_in,
   input wire [N-1:0] func_in,
   output reg [N-1:0] sample_out,
   output reg [N-1:0] pin_out,
   output reg [N-1:0] pin_oe_out
);

   genvar i;

   // ==========================================================
   // per pin capture and output stage
   generate
      for (i = 0; i < N; i = i + 1) begin : g_pin
         // the sample keeps following the pin for the whole reset, so the
         // value seen on the last reset edge is the one that is kept
         always @(posedge clk_in) begin
            if (rst_in) begin
               sample_out[i] <= pin_in[i];
               pin_out[i] <= 1'b0;
               pin_oe_out[i] <= 1'b0;
            end else begin
               sample_out[i] <= sample_out[i];
               pin_out[i] <= func_in[i];
               pin_oe_out[i] <= 1'b1;
            end
         end
      end
   endgenerate

endmodule // strap_pin_bank

// >>> verilog/if_mode_decode.v
// interface mode decoder for the three-bit mode strap
`timescale 1ns/1ps
`include "phy_strap_latch_defs.vh"
module if_mode_decode (
   input wire [2:0] code_in,
   output reg mii_out,
   output reg rmii_out,
   output reg restore_out,
   output reg reserved_out
);

   // ==========================================================
   // decode
   always @* begin
      mii_out = 1'b0;
      rmii_out = 1'b0;
      restore_out = 1'b0;
      reserved_out = 1'b0;
      case (code_in)
         `MODE_MII: begin
            mii_out = 1'b1;
         end
         `MODE_RMII: begin
            rmii_out = 1'b1;
         end
         `MODE_RESTORE: begin
            mii_out = 1'b1;
            restore_out = 1'b1;
         end
         default: begin
            // reserved codes fall back to plain mii so the pins stay sane
            mii_out = 1'b1;
            reserved_out = 1'b1;
         end
      endcase
   end

endmodule // if_mode_decode

// >>> tb/strap_board.sv
// board strap resistors and mac receive inputs on the shared strap pins
`timescale 1ns/1ps
module strap_board (
   input wire [9:0] drive_en_in,
   input wire [9:0] drive_val_in,
   input wire [9:0] dev_out_in,
   input wire [9:0] dev_oe_in,
   input wire [9:0] pull_up_in,
   input wire pull_en_in,
   output wire [9:0] level_out
);
   // ==========================================================
   // pin level
   // an unpulled, undriven pin floats: show the inverse of the device output value
   assign level_out = (dev_oe_in & dev_out_in)
      | (~dev_oe_in & drive_en_in & drive_val_in)
      | (~dev_oe_in & ~drive_en_in & (pull_en_in ? pull_up_in : ~dev_out_in));
endmodule // strap_board

// >>> tb/phy_strap_latch_assertions.sv
// concurrent checks on the strap latch ports
`timescale 1ns/1ps
module phy_strap_latch_assertions (
   input wire CLOCK_IN,
   input wire RST_IN,
   input wire REG_WR_IN,
   input wire MGMT_ADDR_STRAP_BIT0_IN,
   input wire MGMT_ADDR_STRAP_BIT1_IN,
   input wire MGMT_ADDR_STRAP_BIT2_IN,
   input wire IF_MODE_STRAP_BIT0_IN,
   input wire IF_MODE_STRAP_BIT1_IN,
   input wire IF_MODE_STRAP_BIT2_IN,
   input wire ISOLATE_STRAP_IN,
   input wire SPEED_STRAP_IN,
   input wire DUPLEX_STRAP_IN,
   input wire AUTONEG_ENABLE_STRAP_IN,
   input wire SPEED_STRAP_OUT,
   input wire SPEED_STRAP_OE_OUT,
   input wire ISOLATE_STRAP_OE_OUT,
   input wire [9:0] PIN_FUNC_IN,
   input wire STRAP_PULL_EN_OUT,
   input wire [4:0] MGMT_ADDR_OUT,
   input wire [2:0] IF_MODE_OUT,
   input wire MODE_RMII_OUT,
   input wire MODE_RESTORE_OUT,
   input wire ISOLATE_OUT,
   input wire SPEED_100_OUT,
   input wire DUPLEX_BIT_OUT,
   input wire AUTONEG_EN_OUT,
   input wire [3:0] ADV_ABILITY_OUT,
   input wire STRAPS_LOADED_OUT
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);
   // ==========================================================
   // latch on release: outputs of edge k+1 hold the sample of edge k-1
   AST_ADDR_HI: assert property (MGMT_ADDR_OUT[4:3] == 2'b00)
      else $error("address upper bits not zero");
   AST_ADDR_LATCH: assert property ($fell(RST_IN) |=> MGMT_ADDR_OUT ==
      {2'b00, $past(MGMT_ADDR_STRAP_BIT2_IN, 2), $past(MGMT_ADDR_STRAP_BIT1_IN, 2),
      $past(MGMT_ADDR_STRAP_BIT0_IN, 2)}) else $error("address not latched");
   AST_MODE_LATCH: assert property ($fell(RST_IN) |=> IF_MODE_OUT ==
      {$past(IF_MODE_STRAP_BIT2_IN, 2), $past(IF_MODE_STRAP_BIT1_IN, 2),
      $past(IF_MODE_STRAP_BIT0_IN, 2)}) else $error("mode not latched");
   AST_MODE_DECODE: assert property (MODE_RMII_OUT == (IF_MODE_OUT == 3'h1)
      && MODE_RESTORE_OUT == (IF_MODE_OUT == 3'h4)) else $error("mode decode wrong");
   AST_ISO_LATCH: assert property ($fell(RST_IN) |=>
      ISOLATE_OUT == $past(ISOLATE_STRAP_IN, 2)) else $error("isolate not latched");
   AST_SPEED_LATCH: assert property ($fell(RST_IN) |=>
      SPEED_100_OUT == $past(SPEED_STRAP_IN, 2)) else $error("speed not latched");
   AST_ADV_SPEED: assert property ($fell(RST_IN) |=>
      ADV_ABILITY_OUT == ($past(SPEED_STRAP_IN, 2) ? 4'hF : 4'h3))
      else $error("abilities wrong");
   AST_DUPLEX_LATCH: assert property ($fell(RST_IN) |=>
      DUPLEX_BIT_OUT == $past(DUPLEX_STRAP_IN, 2)) else $error("duplex not latched");
   AST_ANEG_LATCH: assert property ($fell(RST_IN) |=>
      AUTONEG_EN_OUT == $past(AUTONEG_ENABLE_STRAP_IN, 2)) else $error("autoneg wrong");
   AST_PINS_REVERT: assert property ($fell(RST_IN) |-> !SPEED_STRAP_OE_OUT
      && STRAP_PULL_EN_OUT ##1 SPEED_STRAP_OE_OUT && ISOLATE_STRAP_OE_OUT
      && !STRAP_PULL_EN_OUT) else $error("pins did not turn to outputs");
   AST_PIN_FUNC: assert property (SPEED_STRAP_OE_OUT && $past(SPEED_STRAP_OE_OUT)
      |-> SPEED_STRAP_OUT == $past(PIN_FUNC_IN[7])) else $error("pin function lost");
   AST_LOADED: assert property ($fell(RST_IN) |-> !STRAPS_LOADED_OUT
      ##1 STRAPS_LOADED_OUT [*3]) else $error("load flag wrong");
   cover property ($fell(RST_IN));
   cover property (MODE_RESTORE_OUT);
   cover property (REG_WR_IN && STRAPS_LOADED_OUT);
endmodule // phy_strap_latch_assertions
bind phy_strap_latch phy_strap_latch_assertions chk (.*);

// >>> tb/testbench.sv
// self-checking bench for the strap latch
`timescale 1ns/1ps
module testbench;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [4:0] addr = 5'h00;
   reg [15:0] wdata = 16'h0000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg rd_seen = 1'b0;
   reg [9:0] func = 10'h000;
   reg [9:0] strap = 10'h000;
   reg [9:0] drv = 10'h000;
   reg [31:0] seed = 32'hB532;
   reg [15:0] exp_q [$];
   reg [9:0] v;
   reg [2:0] a;
   reg rsv;
   integer i;
   integer mismatches = 0;
   integer tests_run = 0;
   wire [15:0] rdata;
   wire [9:0] lvl, po, poe, pull_up;
   wire pull_en, mii, rmii, rest, rsvd_o;
   always #50 clk = ~clk;
   phy_strap_latch dut (
      .CLOCK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .MGMT_ADDR_STRAP_BIT0_IN(lvl[0]), .MGMT_ADDR_STRAP_BIT0_OUT(po[0]),
      .MGMT_ADDR_STRAP_BIT0_OE_OUT(poe[0]), .MGMT_ADDR_STRAP_BIT1_IN(lvl[1]),
      .MGMT_ADDR_STRAP_BIT1_OUT(po[1]), .MGMT_ADDR_STRAP_BIT1_OE_OUT(poe[1]),
      .MGMT_ADDR_STRAP_BIT2_IN(lvl[2]), .MGMT_ADDR_STRAP_BIT2_OUT(po[2]),
      .MGMT_ADDR_STRAP_BIT2_OE_OUT(poe[2]), .IF_MODE_STRAP_BIT0_IN(lvl[3]),
      .IF_MODE_STRAP_BIT0_OUT(po[3]), .IF_MODE_STRAP_BIT0_OE_OUT(poe[3]),
      .IF_MODE_STRAP_BIT1_IN(lvl[4]), .IF_MODE_STRAP_BIT1_OUT(po[4]),
      .IF_MODE_STRAP_BIT1_OE_OUT(poe[4]), .IF_MODE_STRAP_BIT2_IN(lvl[5]),
      .IF_MODE_STRAP_BIT2_OUT(po[5]), .IF_MODE_STRAP_BIT2_OE_OUT(poe[5]),
      .ISOLATE_STRAP_IN(lvl[6]), .ISOLATE_STRAP_OUT(po[6]),
      .ISOLATE_STRAP_OE_OUT(poe[6]), .SPEED_STRAP_IN(lvl[7]), .SPEED_STRAP_OUT(po[7]),
      .SPEED_STRAP_OE_OUT(poe[7]), .DUPLEX_STRAP_IN(lvl[8]), .DUPLEX_STRAP_OUT(po[8]),
      .DUPLEX_STRAP_OE_OUT(poe[8]), .AUTONEG_ENABLE_STRAP_IN(lvl[9]),
      .AUTONEG_ENABLE_STRAP_OUT(po[9]), .AUTONEG_ENABLE_STRAP_OE_OUT(poe[9]),
      .PIN_FUNC_IN(func), .STRAP_PULL_UP_OUT(pull_up), .STRAP_PULL_EN_OUT(pull_en),
      .MGMT_ADDR_OUT(), .IF_MODE_OUT(), .MODE_MII_OUT(mii), .MODE_RMII_OUT(rmii),
      .MODE_RESTORE_OUT(rest), .MODE_RESERVED_OUT(rsvd_o), .ISOLATE_OUT(),
      .SPEED_100_OUT(), .DUPLEX_BIT_OUT(), .AUTONEG_EN_OUT(), .ADV_ABILITY_OUT(),
      .STRAPS_LOADED_OUT());
   strap_board board (.drive_en_in(drv), .drive_val_in(strap), .dev_out_in(po),
      .dev_oe_in(poe), .pull_up_in(pull_up), .pull_en_in(pull_en), .level_out(lvl));
   // ==========================================================
   // helpers
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   task check(input [8*10:1] name, input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task wr_reg(input [4:0] ad, input [15:0] d);
      begin
         addr <= ad;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd_reg(input [4:0] ad, input [15:0] e);
      begin
         exp_q.push_back(e);
         addr <= ad;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         @(posedge clk);
      end
   endtask
   // straps are held through the last reset edge, then the board lets go
   task boot(input [9:0] val, input [9:0] en);
      begin
         seed = xs(seed);
         strap <= val;
         drv <= en;
         rst <= 1'b1;
         func <= seed[25:16];
         repeat (10) @(posedge clk);
         rst <= 1'b0;
         drv <= 10'h000;
         @(negedge clk);
         check("PULL_OE", {pull_en, poe}, 32'h400);
         repeat (3) @(posedge clk);
         @(negedge clk);
         check("PIN_OUT", {poe, po}, {10'h3FF, func});
         @(posedge clk);
      end
   endtask
   // ==========================================================
   // read monitor: data stand only in the cycle after the strobe
   always @(posedge clk)
      rd_seen <= rd;
   always @(negedge clk)
      if (rd_seen)
         check("REG_RDATA", rdata, exp_q.pop_front());
   initial begin
      repeat (5000) @(posedge clk);
      mismatches = mismatches + 1;
      print_verdict;
   end
   // ==========================================================
   // main sequence
   initial begin
      boot(10'h000, 10'h000);
      rd_reg(5'h18, 16'h0201);
      rd_reg(5'h00, 16'h3100);
      rd_reg(5'h04, 16'h01E1);
      for (i = 0; i < 8; i = i + 1) begin
         seed = xs(seed);
         a = (seed[15:0] % 7) + 1;
         v = {seed[19:16], i[2:0], a};
         rsv = !(i == 0 || i == 1 || i == 4);
         boot(v, 10'h3FF);
         check("MODE", {rsvd_o, rest, rmii, mii}, {rsv, i == 4, i == 1, i != 1});
         rd_reg(5'h18, {7'h01, rsv, i[2:0], 2'b00, a});
         rd_reg(5'h00, {2'b00, v[7], v[9], 1'b0, v[6], 1'b0, v[8], 8'h00});
         rd_reg(5'h04, {7'h00, v[7] ? 4'hF : 4'h3, 5'h01});
      end
      wr_reg(5'h00, 16'hFFFF);
      rd_reg(5'h00, 16'h3500);
      wr_reg(5'h04, 16'h0000);
      rd_reg(5'h04, 16'h0001);
      wr_reg(5'h18, 16'h0000);
      rd_reg(5'h18, {7'h01, rsv, 3'h7, 2'b00, a});
      wr_reg(5'h1F, 16'hFFFF);
      rd_reg(5'h1F, 16'h0000);
      boot(10'h000, 10'h000);
      rd_reg(5'h00, 16'h3100);
      @(negedge clk);
      print_verdict;
   end
endmodule // testbench
